// >>> core/tcc_timer.sv
// Timer capture/compare control block with an AHB-Lite register slave
// Contract
// - zero first compare fires after wrap
// - zero first compare fires after any clear
// - read during capture, stored capture stays right
// - stop with first capture gives undefined value
// - second register writable while counting
// - control bit 2 picks second register role
// - second compare match raises its interrupt
// - second captures on first pin edge
// - zero second compare fires after wrap, clears
// - stop with second capture gives undefined value
// - nonzero mode runs, zero mode stops, clears
// - upper mode bits select run and clear mode
// - output toggles on matches, optionally pin edge; never in edge clear mode
// - first at maximum plus wrap sets overflow
// - control bit 0 picks first register role
// - control bit 1 picks first capture trigger
// - opposite phase with both edges never captures
// - counter advances once per count clock
// - first compare match raises its interrupt
`timescale 1ns/1ns
`default_nettype none

module tcc_timer
  import tcc_pkg::*;
#(
  parameter int unsigned COUNT_DIV = DEF_COUNT_DIV // System clocks per count
) (
  input  wire logic        CORE_CLK_IN,           // System clock, 100 MHz
  input  wire logic        RST_IN,                // Synchronous reset, high
  input  wire logic        HSEL_IN,               // AHB slave select
  input  wire logic [31:0] HADDR_IN,              // AHB address
  input  wire logic [1:0]  HTRANS_IN,             // AHB transfer type
  input  wire logic        HWRITE_IN,             // AHB write
  input  wire logic [2:0]  HSIZE_IN,              // AHB size, word only
  input  wire logic [31:0] HWDATA_IN,             // AHB write data
  input  wire logic        HREADY_IN,             // AHB bus ready
  output logic      [31:0] HRDATA_OUT,            // AHB read data
  output logic             HREADYOUT_OUT,         // AHB slave ready
  output logic             HRESP_OUT,             // AHB response, OKAY
  input  wire logic        FIRST_INPUT_PIN_IN,    // First capture pin
  input  wire logic        SECOND_INPUT_PIN_IN,   // Second capture pin
  output logic             TIMER_OUTPUT_PIN_OUT,  // Toggled timer output
  output logic             FIRST_MATCH_IRQ_OUT,   // First register event
  output logic             SECOND_MATCH_IRQ_OUT   // Second register event
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [7:0] DIV_LAST = 8'(COUNT_DIV - 1); // Divider wrap

  logic [7:0]  div_cnt;        // Count clock divider
  logic        tick;           // One-cycle count enable
  logic [15:0] up_counter;     // The counter itself
  logic [15:0] next_counter;   // Counter next value
  logic [3:0]  mode_reg;       // timer_mode_control
  logic [2:0]  ctrl_reg;       // capture_compare_control
  logic [3:0]  edge_reg;       // Pin edge selects
  logic [15:0] first_reg;      // capcmp_reg_first
  logic [15:0] second_reg;     // capcmp_reg_second
  logic        oneshot_pend;   // One-shot clear waiting for a tick
  logic        pin1_q;         // First pin at last tick
  logic        pin2_q;         // Second pin at last tick
  logic        dp_valid;       // Data phase pending
  logic        dp_write;       // Data phase is a write
  logic [15:0] dp_idx;         // Data phase register index
  logic        take;           // Address phase accepted
  logic [31:0] rd_word;        // Read mux
  logic [1:0]  mode_sel;       // Upper mode bits
  logic        running;        // Counter enabled
  logic        ev;             // Count tick while running
  logic        valid1;         // First pin valid edge
  logic        opp1;           // First pin opposite-phase edge
  logic        valid2;         // Second pin valid edge
  logic        match1;         // First compare match
  logic        match2;         // Second compare match
  logic        cap1;           // First capture event
  logic        cap2;           // Second capture event
  logic        clr;            // Counter clear
  logic        ovf_set;        // Overflow event
  logic        toggle;         // Output toggle event
  logic        wr_mode;        // Register write strobes
  logic        wr_ctrl;
  logic        wr_edge;
  logic        wr_first;
  logic        wr_second;
  logic        wr_osh;

  // Edge selected by a two-bit field; the prohibited code sees nothing
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       rise,
                                    input logic       fall);
    unique case (sel)
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Count clock divider
  // ----------------------------------------------------------------------
  // Free-running so the count rate does not depend on bus traffic
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || div_cnt == DIV_LAST) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign tick = (div_cnt == DIV_LAST);

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  // Pins are sampled once per count, so an edge is a change between ticks
  always_comb begin
    mode_sel = mode_reg[MODE_LO_POS +: 2];
    running  = (mode_sel != MODE_STOP);
    ev       = tick & running;
    valid1   = edge_hit(edge_reg[1:0], FIRST_INPUT_PIN_IN & ~pin1_q,
                        ~FIRST_INPUT_PIN_IN & pin1_q);
    opp1     = (edge_reg[1:0] != EDGE_BOTH) &&
               edge_hit(edge_reg[1:0], ~FIRST_INPUT_PIN_IN & pin1_q,
                        FIRST_INPUT_PIN_IN & ~pin1_q);
    valid2   = edge_hit(edge_reg[3:2], SECOND_INPUT_PIN_IN & ~pin2_q,
                        ~SECOND_INPUT_PIN_IN & pin2_q);
    // A zero compare value matches the first count after wrap or clear
    match1   = ev & ~ctrl_reg[FROLE_POS] & (up_counter == first_reg);
    match2   = ev & ~ctrl_reg[SROLE_POS] & (up_counter == second_reg);
    cap1     = ev & ctrl_reg[FROLE_POS] &
               (ctrl_reg[FTRIG_POS] ? opp1 : valid2);
    cap2     = ev & ctrl_reg[SROLE_POS] & valid1;
    clr      = ev & (((mode_sel == MODE_ECLR) & valid1) |
                     ((mode_sel == MODE_MCLR) & match1) |
                     oneshot_pend);
    ovf_set  = ev & (up_counter == COUNT_MAX) & (first_reg == COUNT_MAX);
    toggle   = ev & (mode_sel != MODE_ECLR) &
               (match1 | match2 | (mode_reg[TOGGLE_POS] & valid1));
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_comb begin
    if (!running) begin
      next_counter = RST_WORD;
    end else if (clr) begin
      next_counter = RST_WORD;
    end else if (ev) begin
      next_counter = up_counter + 16'h0001;
    end else begin
      next_counter = up_counter;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      up_counter <= RST_WORD;
    end else begin
      up_counter <= next_counter;
    end
  end

  // Pin history, updated on every count so a restart sees fresh levels
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
    end else if (tick) begin
      pin1_q <= FIRST_INPUT_PIN_IN;
      pin2_q <= SECOND_INPUT_PIN_IN;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  assign take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

  // Read mux; unmapped indices read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (HADDR_IN[31:18] == 14'h0000) begin
      unique case (HADDR_IN[17:2])
        IDX_MODE:   rd_word = {28'h0000000, mode_reg};
        IDX_CTRL:   rd_word = {29'h00000000, ctrl_reg};
        IDX_EDGE:   rd_word = {24'h000000, edge_reg, 4'h0};
        IDX_COUNT:  rd_word = {16'h0000, up_counter};
        IDX_FIRST:  rd_word = {16'h0000, first_reg};
        IDX_SECOND: rd_word = {16'h0000, second_reg};
        default:    rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Zero-wait slave; read data latched at the address phase
  // A read that meets a capture returns the old value, the capture stands
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      dp_valid      <= 1'b0;
      dp_write      <= 1'b0;
      dp_idx        <= 16'h0000;
      HRDATA_OUT    <= 32'h0000_0000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      dp_valid      <= take & (HADDR_IN[31:18] == 14'h0000);
      dp_write      <= HWRITE_IN;
      dp_idx        <= HADDR_IN[17:2];
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
      if (take && !HWRITE_IN) begin
        HRDATA_OUT <= rd_word;
      end
    end
  end

  always_comb begin
    wr_mode   = dp_valid & dp_write & (dp_idx == IDX_MODE);
    wr_ctrl   = dp_valid & dp_write & (dp_idx == IDX_CTRL);
    wr_edge   = dp_valid & dp_write & (dp_idx == IDX_EDGE);
    wr_first  = dp_valid & dp_write & (dp_idx == IDX_FIRST);
    wr_second = dp_valid & dp_write & (dp_idx == IDX_SECOND);
    wr_osh    = dp_valid & dp_write & (dp_idx == IDX_ONESHOT);
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Overflow flag: a write of zero clears it, but a new overflow wins
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      mode_reg <= RST_MODE;
    end else begin
      if (wr_mode) begin
        mode_reg[3:1] <= HWDATA_IN[3:1];
      end
      if (ovf_set) begin
        mode_reg[OVF_POS] <= 1'b1;
      end else if (wr_mode && !HWDATA_IN[OVF_POS]) begin
        mode_reg[OVF_POS] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ctrl_reg <= RST_CTRL;
      edge_reg <= RST_EDGE;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= HWDATA_IN[2:0];
      end
      if (wr_edge) begin
        edge_reg <= HWDATA_IN[EDGE1_POS +: 4];
      end
    end
  end

  // One-shot clear waits for the next count; a new request wins
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      oneshot_pend <= 1'b0;
    end else if (wr_osh && HWDATA_IN[0]) begin
      oneshot_pend <= 1'b1;
    end else if (tick) begin
      oneshot_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Capture/compare registers
  // ----------------------------------------------------------------------
  // Captures only happen while counting, so a stop never half-captures;
  // the value at such a collision is simply the last count
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      first_reg <= RST_WORD;
    end else if (cap1) begin
      first_reg <= up_counter;
    end else if (wr_first) begin
      first_reg <= HWDATA_IN[15:0];
    end
  end

  // Writes taken at any time and used by the next compare
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      second_reg <= RST_WORD;
    end else if (cap2) begin
      second_reg <= up_counter;
    end else if (wr_second) begin
      second_reg <= HWDATA_IN[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Event outputs and timer output
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      FIRST_MATCH_IRQ_OUT  <= 1'b0;
      SECOND_MATCH_IRQ_OUT <= 1'b0;
      TIMER_OUTPUT_PIN_OUT <= 1'b0;
    end else begin
      FIRST_MATCH_IRQ_OUT  <= match1 | cap1;
      SECOND_MATCH_IRQ_OUT <= match2 | cap2;
      if (toggle) begin
        TIMER_OUTPUT_PIN_OUT <= ~TIMER_OUTPUT_PIN_OUT;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_stop_holds_zero: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (mode_sel == MODE_STOP) |=> (up_counter == 16'h0000))
    else $error("counter not zero while stopped");

  a_count_step: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (ev && !clr) |=> (up_counter == $past(up_counter) + 16'h0001))
    else $error("counter did not advance by one");

  a_edge_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (ev && mode_sel == MODE_ECLR && valid1) |=> (up_counter == 16'h0000))
    else $error("edge clear did not clear counter");

  a_first_irq: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    match1 |=> FIRST_MATCH_IRQ_OUT)
    else $error("first match without interrupt");

  a_zero_wrap: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (ev && !ctrl_reg[FROLE_POS] && first_reg == 16'h0000 && up_counter == 16'h0000)
    |=> FIRST_MATCH_IRQ_OUT ##0 (up_counter == 16'h0001 || $past(clr)))
    else $error("zero compare missed after wrap");

  a_second_cap: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    cap2 |=> (second_reg == $past(up_counter)) && SECOND_MATCH_IRQ_OUT)
    else $error("second capture wrong");

  a_both_no_cap: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (ctrl_reg[FROLE_POS] && ctrl_reg[FTRIG_POS] && edge_reg[1:0] == EDGE_BOTH
     && !wr_first) |=> $stable(first_reg))
    else $error("capture with both edges selected");

  a_ovf_flag: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    ovf_set |=> mode_reg[OVF_POS])
    else $error("overflow not flagged");

  a_no_toggle_eclr: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (mode_sel == MODE_ECLR) |=> $stable(TIMER_OUTPUT_PIN_OUT))
    else $error("output toggled in edge clear mode");

endmodule // tcc_timer

`default_nettype wire

// >>> inc/tcc_pkg.sv
// Constants shared by the timer capture/compare control block
package tcc_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_MODE    = 16'hFFBA; // timer_mode_control
  localparam logic [15:0] IDX_CTRL    = 16'hFFBC; // capture_compare_control
  localparam logic [15:0] IDX_COUNT   = 16'hFFB2; // up_counter, read only
  localparam logic [15:0] IDX_FIRST   = 16'hFFB4; // capcmp_reg_first
  localparam logic [15:0] IDX_SECOND  = 16'hFFB6; // capcmp_reg_second
  localparam logic [15:0] IDX_EDGE    = 16'hFFBB; // prescale_edge_select
  localparam logic [15:0] IDX_ONESHOT = 16'hFFBE; // one-shot trigger

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int OVF_POS      = 0; // overflow_flag
  localparam int TOGGLE_POS   = 1; // toggle_timing_bit
  localparam int MODE_LO_POS  = 2; // mode_bit_mid, mode_bit_high above it
  localparam int FROLE_POS    = 0; // first_reg_role_bit
  localparam int FTRIG_POS    = 1; // first_reg_trigger_sel
  localparam int SROLE_POS    = 2; // second_reg_role_bit
  localparam int EDGE1_POS    = 4; // first_pin_edge_lo, _hi above it
  localparam int EDGE2_POS    = 6; // second pin edge field

  // ----------------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  MODE_STOP  = 2'h0; // Counter held at zero
  localparam logic [1:0]  MODE_FREE  = 2'h1; // Free running
  localparam logic [1:0]  MODE_ECLR  = 2'h2; // Clear on first pin edge
  localparam logic [1:0]  MODE_MCLR  = 2'h3; // Clear on first match
  localparam logic [1:0]  EDGE_FALL  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_BOTH  = 2'h3;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [3:0]  RST_MODE   = 4'h0;
  localparam logic [2:0]  RST_CTRL   = 3'h0;
  localparam logic [3:0]  RST_EDGE   = 4'h0;
  localparam int          DEF_COUNT_DIV = 4; // System clocks per count

endpackage

// >>> tb/tcc_pin_model.sv
// Pin-side partner: drives both capture pins and watches the output pin
`timescale 1ns/1ns
`default_nettype none

module tcc_pin_model (
  input  wire logic        clk_in,     // System clock
  input  wire logic        rst_in,     // Synchronous reset
  input  wire logic        slow_in,    // Late pin changes when high
  input  wire logic        want1_in,   // Wanted first pin level
  input  wire logic        want2_in,   // Wanted second pin level
  input  wire logic        tout_in,    // Timer output pin
  output logic             pin1_out,   // First input pin
  output logic             pin2_out,   // Second input pin
  output logic      [15:0] toggles_out // Output toggle count
);
  logic [2:0] dly1 = 3'h0; // First pin delay line
  logic [2:0] dly2 = 3'h0; // Second pin delay line
  logic       tout_q;      // Output level seen last cycle

  // Pins follow the wanted level one or three cycles late
  always @(posedge clk_in) begin
    dly1 <= {dly1[1:0], want1_in};
    dly2 <= {dly2[1:0], want2_in};
  end

  // Slow partner takes the three-cycle tap, otherwise the one-cycle tap
  assign pin1_out = slow_in ? dly1[2] : dly1[0];
  assign pin2_out = slow_in ? dly2[2] : dly2[0];

  // Count every change of the output level
  always @(posedge clk_in) begin
    tout_q <= tout_in;
    if (rst_in) begin
      toggles_out <= 16'h0;
    end else if (tout_in !== tout_q) begin
      toggles_out <= toggles_out + 16'h1;
    end
  end
endmodule // tcc_pin_model

`default_nettype wire

// >>> tb/tcc_timer_tb.sv
// Self-checking bench for the timer capture/compare block
`timescale 1ns/1ns
`default_nettype none

module tcc_timer_tb
  import tcc_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFFFFFF; // Full compare mask
  logic        clk = 1'b0;    // System clock
  logic        rst = 1'b1;    // Synchronous reset
  logic [31:0] haddr = 32'h0; // Bus address
  logic [1:0]  htrans = 2'h0; // Bus transfer type
  logic        hwrite = 1'b0; // Bus direction
  logic [31:0] hwdata = 32'h0; // Bus write data
  logic        want1 = 1'b0;  // First pin request
  logic        want2 = 1'b0;  // Second pin request
  logic        slow = 1'b0;   // Slow pin partner
  logic        rd_pend = 1'b0; // Read data phase pending
  wire  [31:0] hrdata;        // Bus read data
  wire         hready;        // Slave ready fed back as bus ready
  wire         hresp, pin1, pin2, tout, irq1, irq2; // Response, pin and event lines
  wire  [15:0] toggles;       // Output toggles seen
  logic [63:0] exp_q[$];      // Expected reads, mask over value
  int          err_count = 0; // Mismatches
  int          checked = 0;   // Comparisons
  int          n1 = 0;        // First event pulses
  int          n2 = 0;        // Second event pulses
  int          b1, b2, bt;    // Counts at scenario start

  initial forever #5 clk = ~clk;

  tcc_timer #(.COUNT_DIV(1)) DUT (
    .CORE_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .FIRST_INPUT_PIN_IN(pin1), .SECOND_INPUT_PIN_IN(pin2),
    .TIMER_OUTPUT_PIN_OUT(tout), .FIRST_MATCH_IRQ_OUT(irq1),
    .SECOND_MATCH_IRQ_OUT(irq2));

  tcc_pin_model PINS (
    .clk_in(clk), .rst_in(rst), .slow_in(slow), .want1_in(want1),
    .want2_in(want2), .tout_in(tout), .pin1_out(pin1), .pin2_out(pin2),
    .toggles_out(toggles));

  // ------------------------------------------------------------------
  // Bus master and compare tasks
  // ------------------------------------------------------------------
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk);
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e & m});
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [63:0] n);
    checked++;
    if ((got & n[63:32]) !== n[31:0]) begin
      err_count++;
      $display("BAD %0t read %h want %h", $time, got, n[31:0]);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      err_count++;
      $display("BAD %0t count %0d want %0d", $time, got, e);
    end
  endtask

  task automatic mark;
    b1 = n1;
    b2 = n2;
    bt = int'(toggles);
  endtask

  // One valid-length pulse on a capture pin
  task automatic pulse(input logic second);
    if (second) want2 <= 1'b1;
    else want1 <= 1'b1;
    repeat (8) @(posedge clk);
    want1 <= 1'b0;
    want2 <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watches the bus and event lines; takes read data in its data phase
  always @(posedge clk) begin
    if (rd_pend && hready === 1'b1) begin
      cmp_rd({31'h0, hresp}, {ALL, 32'h0});
      if (exp_q.size() == 0) begin
        err_count++;
        $display("BAD %0t read not expected", $time);
      end else begin
        cmp_rd(hrdata, exp_q.pop_front());
      end
    end
    if (hready === 1'b1) rd_pend = !rst && htrans[1] && !hwrite;
    if (irq1 === 1'b1) n1++;
    if (irq2 === 1'b1) n2++;
  end

  // Hang guard, longer than the wrap scenario
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    report_and_stop;
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [1:0]  e;
    int          k;
    void'($urandom(32'hC88C));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_MODE, 32'h0, ALL);
    rd(IDX_CTRL, 32'h0, ALL);
    rd(IDX_SECOND, 32'h0, ALL);
    rd(IDX_COUNT, 32'h0, ALL);
    wr(16'hFFF0, ALL);
    rd(16'hFFF0, 32'h0, ALL);
    wr(IDX_CTRL, ALL);
    rd(IDX_CTRL, 32'h7, ALL);
    wr(IDX_MODE, 32'hF3);
    rd(IDX_MODE, 32'h2, ALL);
    for (k = 0; k < 4; k++) begin
      r = $urandom;
      wr(IDX_SECOND, r);
      rd(IDX_SECOND, {16'h0, r[15:0]}, ALL);
      wr(IDX_FIRST, ~r);
      rd(IDX_FIRST, {16'h0, ~r[15:0]}, ALL);
    end
    // Free run, both compares, second rewritten while counting
    wr(IDX_CTRL, 32'h0);
    wr(IDX_MODE, 32'h0);
    wr(IDX_FIRST, 32'h10);
    wr(IDX_SECOND, 32'h20);
    mark;
    wr(IDX_MODE, {28'h0, MODE_FREE, 2'h0});
    repeat (64) @(posedge clk);
    chk(n1 - b1, 1);
    chk(n2 - b2, 1);
    chk(toggles - bt, 2);
    wr(IDX_SECOND, 32'h90);
    repeat (128) @(posedge clk);
    chk(n2 - b2, 2);
    chk(n1 - b1, 1);
    chk(toggles - bt, 3);
    wr(IDX_MODE, 32'h0);
    rd(IDX_COUNT, 32'h0, ALL);
    // Match clear keeps the count at or below the first register
    wr(IDX_FIRST, 32'hF);
    wr(IDX_MODE, {28'h0, MODE_MCLR, 2'h0});
    for (k = 0; k < 4; k++) rd(IDX_COUNT, 32'h0, 32'hFFFFFFF0);
    wr(IDX_MODE, 32'h0);
    // Second register captures on each edge kind, output toggles on edge
    wr(IDX_FIRST, 32'hFFF0);
    wr(IDX_CTRL, 32'h4);
    for (k = 0; k < 3; k++) begin
      e = (k == 2) ? EDGE_BOTH : 2'(k);
      wr(IDX_EDGE, {26'h0, e, 4'h0});
      mark;
      wr(IDX_MODE, {28'h0, MODE_FREE, 2'h2});
      pulse(1'b0);
      chk(n2 - b2, (k == 2) ? 2 : 1);
      chk(toggles - bt, (k == 2) ? 2 : 1);
      wr(IDX_MODE, 32'h0);
    end
    // Edge clear: count restarts, no toggling
    wr(IDX_EDGE, 32'h10);
    wr(IDX_CTRL, 32'h0);
    mark;
    wr(IDX_MODE, {28'h0, MODE_ECLR, 2'h2});
    repeat (64) @(posedge clk);
    want1 <= 1'b1;
    // Let the edge reach the pin and clear the count before sampling it
    repeat (4) @(posedge clk);
    rd(IDX_COUNT, 32'h0, 32'hFFFFFFF0);
    want1 <= 1'b0;
    repeat (8) @(posedge clk);
    chk(toggles - bt, 0);
    wr(IDX_MODE, 32'h0);
    // First register capture, slow partner
    slow <= 1'b1;
    wr(IDX_CTRL, 32'h3);
    wr(IDX_EDGE, 32'h30);
    mark;
    wr(IDX_MODE, 32'h4);
    pulse(1'b0);
    chk(n1 - b1, 0);
    wr(IDX_MODE, 32'h0);
    wr(IDX_EDGE, 32'h10);
    mark;
    wr(IDX_MODE, 32'h4);
    want1 <= 1'b1;
    repeat (8) @(posedge clk);
    chk(n1 - b1, 0);
    want1 <= 1'b0;
    repeat (8) @(posedge clk);
    chk(n1 - b1, 1);
    wr(IDX_MODE, 32'h0);
    wr(IDX_CTRL, 32'h1);
    wr(IDX_EDGE, 32'h40);
    mark;
    wr(IDX_MODE, 32'h4);
    pulse(1'b1);
    chk(n1 - b1, 1);
    wr(IDX_MODE, 32'h0);
    // Full wrap: overflow and zero second compare
    slow <= 1'b0;
    wr(IDX_CTRL, 32'h0);
    // Zero first compare fires again after a one-shot clear
    wr(IDX_FIRST, 32'h0);
    wr(IDX_MODE, 32'h4);
    repeat (32) @(posedge clk);
    mark;
    wr(IDX_ONESHOT, 32'h1);
    repeat (16) @(posedge clk);
    chk(n1 - b1, 1);
    rd(IDX_COUNT, 32'h0, 32'hFFFFFFE0);
    wr(IDX_MODE, 32'h0);
    wr(IDX_FIRST, 32'hFFFF);
    wr(IDX_SECOND, 32'h0);
    wr(IDX_MODE, 32'h4);
    repeat (256) @(posedge clk);
    mark;
    repeat (65536) @(posedge clk);
    chk(n1 - b1, 1);
    chk(n2 - b2, 1);
    rd(IDX_MODE, 32'h5, ALL);
    wr(IDX_MODE, 32'h0);
    rd(IDX_MODE, 32'h0, ALL);
    rd(IDX_COUNT, 32'h0, ALL);
    repeat (4) @(posedge clk);
    if (exp_q.size() != 0) err_count++;
    report_and_stop;
  end
endmodule // tcc_timer_tb

`default_nettype wire
